// ### rco_pkg.sv
// Purpose: Shared constants and types for the reset indicator and cause log.
// Assumes: One 25 MHz system clock; byte-wide register port.
// Notes: Offsets and bit positions of the cause register and the status group.
package rco_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned PULSE_CLKS = 256;
  localparam int unsigned POWERUP_MAX_CLKS = 258;
  localparam logic [3:0] ADDR_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h1;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h2;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h3;
  localparam int unsigned BIT_OE = 7;
  localparam int unsigned BIT_WD = 2;
  localparam int unsigned BIT_CMD = 1;
  localparam int unsigned BIT_EXT = 0;
  localparam logic [7:0] CAUSE_RESET = 8'h01;
  localparam logic [7:0] WRITE_MASK = 8'h80;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam int unsigned EVT_PULSE_DONE = 1;
  localparam int unsigned EVT_PULSE_START = 0;
  localparam logic [1:0] EVT_RESET = 2'h0;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rco_bus_req_t;
  typedef struct packed {
    logic ext;
    logic cmd;
    logic wd;
  } rco_rst_src_t;
endpackage

// ### rco_reset_out.sv
// Purpose: Reset indication output pulse and reset-cause register.
// Assumes: Reset-source strobes are one-cycle pulses synchronous to core_clk.
// Notes: The pin is driven low while the pulse runs and released to high otherwise.
`timescale 1ns/1ps
module rco_reset_out #(
  parameter int unsigned PULSE_LEN = rco_pkg::PULSE_CLKS
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire rco_pkg::rco_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire rco_pkg::rco_rst_src_t rst_src,
  output logic shared_port_pin_o,
  output logic shared_port_pin_oe,
  output logic internal_reset_indicator_out,
  output logic irq
);
  import rco_pkg::*;

  // ****************************************************************
  // Parameter checks
  // ****************************************************************

  // The pulse counter is 16 bits wide, so a longer pulse cannot be timed.
  if (PULSE_LEN < 1 || PULSE_LEN > 65535) begin : g_bad_len
    $error("PULSE_LEN out of range");
  end

  localparam int unsigned N_EVT = 2;
  localparam logic [15:0] CNT_LAST = 16'(PULSE_LEN - 1);
  localparam logic [7:0] CAUSE_READ_MASK = WRITE_MASK | 8'h07;

  // The status and enable bits must fit the byte-wide read port.
  if (N_EVT > 8) begin : g_bad_evt
    $error("N_EVT out of range");
  end

  // ****************************************************************
  // State
  // ****************************************************************

  logic [7:0] cause_r;
  logic [7:0] cause_nxt;
  logic [N_EVT-1:0] stat_r;
  logic [N_EVT-1:0] stat_nxt;
  logic [N_EVT-1:0] en_r;
  logic [N_EVT-1:0] en_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic pin_low_r;
  logic pin_low_nxt;
  logic pin_hi_r;
  logic oe_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;

  // ****************************************************************
  // Register decode
  // ****************************************************************

  wire wr_cause;
  wire wr_en;
  wire wr_clr;
  wire rd_cause;
  wire rd_stat;
  wire rd_en;
  wire [N_EVT-1:0] clr_bits;

  assign wr_cause = bus_req.wr && (bus_req.addr == ADDR_CAUSE);
  assign wr_en = bus_req.wr && (bus_req.addr == ADDR_IRQ_EN);
  assign wr_clr = bus_req.wr && (bus_req.addr == ADDR_IRQ_CLR);
  assign rd_cause = bus_req.rd && (bus_req.addr == ADDR_CAUSE);
  assign rd_stat = bus_req.rd && (bus_req.addr == ADDR_IRQ_STAT);
  assign rd_en = bus_req.rd && (bus_req.addr == ADDR_IRQ_EN);
  assign clr_bits = wr_clr ? bus_req.wdata[N_EVT-1:0] : {N_EVT{1'b0}};

  // ****************************************************************
  // Reset sources
  // ****************************************************************

  wire src_ext;
  wire src_cmd;
  wire src_wd;
  wire any_src;
  wire internal_rst;

  assign src_ext = rst_src.ext;
  assign src_cmd = rst_src.cmd;
  assign src_wd = rst_src.wd;
  assign any_src = src_ext | src_cmd | src_wd;
  // An external reset masks internal ones in the same cycle, so a pulse that is
  // wired back to the input can never retrigger itself.
  assign internal_rst = (src_cmd | src_wd) & ~src_ext;

  // ****************************************************************
  // Cause register
  // ****************************************************************

  // Priority is external, then instruction, then watchdog, so exactly one flag
  // stays set even when sources coincide.
  wire flag_ext_nxt = src_ext;
  wire flag_cmd_nxt = src_cmd & ~src_ext;
  wire flag_wd_nxt = src_wd & ~src_ext & ~src_cmd;
  wire oe_bit_nxt = wr_cause ? bus_req.wdata[BIT_OE] : cause_r[BIT_OE];

  always_comb begin
    cause_nxt = cause_r;
    cause_nxt[BIT_OE] = oe_bit_nxt;
    if (any_src) begin
      cause_nxt[BIT_EXT] = flag_ext_nxt;
      cause_nxt[BIT_CMD] = flag_cmd_nxt;
      cause_nxt[BIT_WD] = flag_wd_nxt;
    end
  end

  // Only the enable bit and the one-hot cause flags can ever hold a one.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cause_r <= CAUSE_RESET;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // ****************************************************************
  // Pulse control
  // ****************************************************************

  wire output_on = cause_r[BIT_OE];
  wire start = output_on && internal_rst && !pin_low_r;
  wire last = pin_low_r && (cnt_r == CNT_LAST);

  // A trigger that arrives while a pulse runs is dropped, not restarted.
  always_comb begin
    cnt_nxt = cnt_r;
    pin_low_nxt = pin_low_r;
    if (start) begin
      pin_low_nxt = 1'b1;
      cnt_nxt = 16'h0000;
    end else if (last) begin
      pin_low_nxt = 1'b0;
      cnt_nxt = 16'h0000;
    end else if (pin_low_r) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  // ****************************************************************
  // Pulse counter
  // ****************************************************************

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************************************
  // Pulse state
  // ****************************************************************

  // Reset releases the pin, so the power-on low time is zero clocks.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pin_low_r <= 1'b0;
    end else begin
      pin_low_r <= pin_low_nxt;
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************

  // Level and enable both come from flops so that no decode glitch reaches the pin.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pin_hi_r <= 1'b1;
    end else begin
      pin_hi_r <= ~pin_low_nxt;
    end
  end

  // The pin belongs to this function whenever the block runs.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      oe_r <= 1'b1;
    end else begin
      oe_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************

  wire [N_EVT-1:0] evt;
  assign evt[EVT_PULSE_START] = start;
  assign evt[EVT_PULSE_DONE] = last;

  for (genvar i = 0; i < N_EVT; i++) begin : g_evt
    // A new event wins over a clear in the same cycle.
    assign stat_nxt[i] = evt[i] | (stat_r[i] & ~clr_bits[i]);
    assign en_nxt[i] = wr_en ? bus_req.wdata[i] : en_r[i];
  end

  assign irq_nxt = |(stat_nxt & en_nxt);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stat_r <= EVT_RESET;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ****************************************************************
  // Interrupt enable
  // ****************************************************************

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      en_r <= EVT_RESET;
    end else begin
      en_r <= en_nxt;
    end
  end

  // ****************************************************************
  // Interrupt output
  // ****************************************************************

  // The line follows the next status and enable, so it rises with the event.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************

  wire [7:0] rdata_cause = cause_r & CAUSE_READ_MASK;
  wire [7:0] rdata_stat = {{(8 - N_EVT){1'b0}}, stat_r};
  wire [7:0] rdata_en = {{(8 - N_EVT){1'b0}}, en_r};

  // Unmapped offsets and idle cycles read as zero.
  always_comb begin
    rdata_nxt = UNMAPPED_DATA;
    if (rd_cause) begin
      rdata_nxt = rdata_cause;
    end else if (rd_stat) begin
      rdata_nxt = rdata_stat;
    end else if (rd_en) begin
      rdata_nxt = rdata_en;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata_r <= UNMAPPED_DATA;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  assign shared_port_pin_o = pin_hi_r;
  assign shared_port_pin_oe = oe_r;
  assign internal_reset_indicator_out = pin_hi_r;
  assign bus_rdata = rdata_r;
  assign irq = irq_r;
endmodule

// ### rco_reset_out_monitor.sv
// Purpose: Port checker for the reset indicator and cause log.
// Assumes: The enable bit follows bus writes to the cause register.
// Notes: Low clocks of a pulse are counted in cnt_r.
`timescale 1ns/1ps
module rco_reset_out_monitor import rco_pkg::*; #(parameter int unsigned PULSE_LEN = 256) (
  input wire logic core_clk, input wire logic nrst, input wire rco_pkg::rco_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata, input wire rco_pkg::rco_rst_src_t rst_src,
  input wire logic shared_port_pin_o, input wire logic shared_port_pin_oe,
  input wire logic internal_reset_indicator_out);
  logic en_r;
  logic [16:0] cnt_r;
  wire p = shared_port_pin_o;
  always_ff @(posedge core_clk) begin
    en_r <= !nrst ? 1'b0 : bus_req.wr && bus_req.addr == ADDR_CAUSE ? bus_req.wdata[7] : en_r;
    cnt_r <= p ? 17'h0_0000 : cnt_r + 17'h0_0001;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_pin_same: assert property (internal_reset_indicator_out == p) else $error("copy");
  chk_oe_held: assert property (shared_port_pin_oe) else $error("oe");
  chk_ext_quiet: assert property (rst_src == 3'h4 && p |=> p) else $error("ext");
  chk_int_pulse: assert property (!rst_src.ext && |rst_src[1:0] && en_r && p |=> !p)
    else $error("no pulse");
  chk_dis_quiet: assert property (!en_r && p |=> p) else $error("off");
  chk_pulse_len: assert property ($rose(p) |-> cnt_r == PULSE_LEN) else $error("len");
  chk_pulse_max: assert property (!p |-> cnt_r < PULSE_LEN) else $error("long");
  chk_rd_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00) else $error("rd");
  chk_cause_fmt: assert property ($past(bus_req.rd) && $past(bus_req.addr) == ADDR_CAUSE |->
    bus_rdata[6:3] == 4'h0 && $onehot(bus_rdata[2:0])) else $error("cause");
endmodule
bind rco_reset_out rco_reset_out_monitor #(.PULSE_LEN(PULSE_LEN)) rco_reset_out_monitor_i (.*);

// ### rco_rx_model.sv
// Purpose: Receiver of the reset indication.
// Assumes: One clock.
// Notes: Counts falling edges of the pin.
`timescale 1ns/1ps
module rco_rx_model (input wire logic core_clk, input wire logic nrst,
  input wire logic pin, output logic [7:0] n_pulse);
  always_ff @(posedge core_clk)
    n_pulse <= !nrst ? 8'h00 : n_pulse + 8'($fell(pin));
endmodule

// ### reset_out_and_cause_log_tb.sv
// Purpose: Bench for the reset indicator and cause log.
// Assumes: Pulse length cut to four clocks.
// Notes: The receiver model counts pulses.
`timescale 1ns/1ps
module reset_out_and_cause_log_tb;
  import rco_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  rco_bus_req_t rq = '0;
  rco_rst_src_t src = '0;
  logic [7:0] rdat, np;
  logic pin, irq, oe;
  int num_errors = 0;
  int n_checks = 0;
  initial forever #20 core_clk = ~core_clk;
  rco_reset_out #(.PULSE_LEN(4)) rco_reset_out_i (.core_clk, .nrst, .bus_req(rq), .bus_rdata(rdat),
    .rst_src(src), .shared_port_pin_o(pin), .shared_port_pin_oe(oe), .internal_reset_indicator_out(),
    .irq);
  rco_rx_model rco_rx_model_i (.core_clk, .nrst, .pin, .n_pulse(np));
  task automatic chk(input string s, input logic [7:0] e, g);
    n_checks++;
    num_errors += int'(g !== e);
    if (g !== e) $display("[FAIL] %s exp %h got %h", s, e, g);
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk) rq <= '{a, d, w, !w};
    @(posedge core_clk) rq <= '0;
    #1 if (!w) chk("rdata", d, rdat);
  endtask
  task automatic fire(input logic [2:0] s, input logic [7:0] len);
    logic [7:0] n = 8'h00;
    @(posedge core_clk) src <= s;
    @(posedge core_clk) src <= 3'h0;
    repeat (8) begin
      #1 n += 8'(!pin);
      @(posedge core_clk);
    end
    #1 chk("low", len, n);
  endtask
  task automatic t_off();
    acc(1'b0, ADDR_CAUSE, 8'h01);
    chk("oe", 8'h01, 8'(oe));
    fire(3'h2, 8'h00);
    acc(1'b0, ADDR_CAUSE, 8'h02);
    $display("t_off end");
  endtask
  task automatic t_wd();
    acc(1'b1, ADDR_CAUSE, 8'h80);
    fire(3'h1, 8'h04);
    chk("irq", 8'h00, 8'(irq));
    acc(1'b1, ADDR_IRQ_EN, 8'h03);
    acc(1'b0, ADDR_IRQ_STAT, 8'h03);
    chk("irq", 8'h01, 8'(irq));
    acc(1'b1, ADDR_IRQ_CLR, 8'h03);
    acc(1'b0, ADDR_CAUSE, 8'h84);
    chk("irq", 8'h00, 8'(irq));
    $display("t_wd end");
  endtask
  task automatic t_ext();
    fire(3'h2, 8'h04);
    fire(3'h4, 8'h00);
    fire(3'h6, 8'h00);
    acc(1'b0, ADDR_CAUSE, 8'h81);
    acc(1'b0, 4'hF, 8'h00);
    chk("pulses", 8'h02, np);
    $display("t_ext end");
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    t_off();
    t_wd();
    t_ext();
    wrap_up();
  end
endmodule
